// ### src/i2st_regs.vh
// Register map, field positions and reset values of the serial bus status block.
// Included by the block's single design file; definitions only.
`ifndef I2ST_REGS_VH
`define I2ST_REGS_VH

// Register offsets (byte addresses, one 32-bit word each)
`define I2ST_OFF_STATUS 8'h00
`define I2ST_OFF_CTRL 8'h04
`define I2ST_OFF_RXHOLD 8'h08
`define I2ST_OFF_TXHOLD 8'h0C
`define I2ST_OFF_IRQ_STAT 8'h10
`define I2ST_OFF_IRQ_MASK 8'h14

// Status register bit positions
`define I2ST_ST_DATA 5
`define I2ST_ST_STOP 4
`define I2ST_ST_START 3
`define I2ST_ST_READ 2
`define I2ST_ST_RXFULL 1
`define I2ST_ST_TXFULL 0

// Control register fields
`define I2ST_CTRL_ADDR_HI 6
`define I2ST_CTRL_EN 7
`define I2ST_OWN_ADDR_RST 7'h2A
`define I2ST_EN_RST 1'h0

// Interrupt status and mask bit positions
`define I2ST_EV_RX 0
`define I2ST_EV_TXDONE 1
`define I2ST_EV_STOP 2
`define I2ST_EV_ADDR 3
`define I2ST_EV_W 4

// Bits in a byte on the wire, and the count that ends one
`define I2ST_BYTE_BITS 4'h8

`endif

// ### src/i2st_top.v
// Status-flag tracker of a two-wire serial bus slave port, with register port and interrupt.
// Assumes SCL and SDA come from outside and are resolved by the bench from SDA_OE.
// How it works
// - Address match clears, received data byte sets data flag
// - Stop flag high only after last stop
// - Start flag high only after last start
// - Address byte bit sets read direction flag
// - Received byte sets full; software read clears
// - Software write sets transmit full; sent clears
// - Start and stop flags update together
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "i2st_regs.vh"

module i2st_top (
    // Clock and reset
    input wire SYS_CLK,
    input wire SYS_RST,
    // Serial bus pins
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    // Register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // Interrupt
    output reg IRQ
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACK_A = 3'h2;
    localparam [2:0] ST_RXD = 3'h3;
    localparam [2:0] ST_ACK_D = 3'h4;
    localparam [2:0] ST_TXD = 3'h5;
    localparam [2:0] ST_TXACK = 3'h6;

    // Synchronisers: stage one feeds stage two only
    reg scl_s1_reg;
    reg scl_s2_reg;
    reg scl_s3_reg;
    reg sda_s1_reg;
    reg sda_s2_reg;
    reg sda_s3_reg;

    reg [2:0] state_reg;
    reg [3:0] cnt_reg;
    reg [7:0] rx_sh_reg;
    reg [7:0] tx_sh_reg;
    reg nack_reg;
    reg [7:0] rx_hold_reg;
    reg [7:0] tx_hold_reg;
    reg [6:0] own_addr_reg;
    reg en_reg;
    // Status flags as software sees them
    reg data_reg;
    reg stop_reg;
    reg start_reg;
    reg read_reg;
    reg rxfull_reg;
    reg txfull_reg;
    reg [`I2ST_EV_W-1:0] ist_reg;
    reg [`I2ST_EV_W-1:0] imask_reg;

    wire scl_rise = scl_s2_reg & ~scl_s3_reg;
    wire scl_fall = ~scl_s2_reg & scl_s3_reg;
    wire scl_hi = scl_s2_reg & scl_s3_reg;
    // Conditions compare settled stages, so both lines are seen at one instant
    wire bus_start = scl_hi & sda_s3_reg & ~sda_s2_reg;
    wire bus_stop = scl_hi & ~sda_s3_reg & sda_s2_reg;
    wire byte_done = (cnt_reg == `I2ST_BYTE_BITS);
    // Own address only counts while the port is enabled
    wire addr_hit = en_reg && (rx_sh_reg[7:1] == own_addr_reg);
    wire wr_status = WR && (ADDR == `I2ST_OFF_CTRL);
    wire rd_rxhold = RD && (ADDR == `I2ST_OFF_RXHOLD);
    wire wr_txhold = WR && (ADDR == `I2ST_OFF_TXHOLD);

    // Events of this cycle, produced by the bus engine
    reg ev_rx;
    reg ev_txdone;
    reg ev_addr;
    always @* begin
        ev_rx = 1'b0;
        ev_txdone = 1'b0;
        ev_addr = 1'b0;
        if (!bus_start && !bus_stop && scl_fall) begin
            if (state_reg == ST_ADDR && byte_done && addr_hit) begin
                ev_addr = 1'b1;
            end
            if (state_reg == ST_RXD && byte_done) begin
                ev_rx = 1'b1;
            end
            if (state_reg == ST_TXD && byte_done) begin
                ev_txdone = 1'b1;
            end
        end
    end

    // Write decodes and event word of the interrupt status
    wire wr_irq_stat = WR && (ADDR == `I2ST_OFF_IRQ_STAT);
    wire wr_irq_mask = WR && (ADDR == `I2ST_OFF_IRQ_MASK);
    wire [`I2ST_EV_W-1:0] ev_vec = {ev_addr, bus_stop, ev_txdone, ev_rx};
    wire [`I2ST_EV_W-1:0] ist_clr = wr_irq_stat ? WDATA[`I2ST_EV_W-1:0] : {`I2ST_EV_W{1'b0}};

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            scl_s1_reg <= 1'h1;
            scl_s2_reg <= 1'h1;
            scl_s3_reg <= 1'h1;
            sda_s1_reg <= 1'h1;
            sda_s2_reg <= 1'h1;
            sda_s3_reg <= 1'h1;
        end else begin
            scl_s1_reg <= SCL_IN;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= SDA_IN;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    // Bus engine; conditions override any byte in progress
    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            rx_sh_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            nack_reg <= 1'h0;
            SDA_OUT <= 1'h0;
            SDA_OE <= 1'h0;
            start_reg <= 1'h0;
            stop_reg <= 1'h0;
            data_reg <= 1'h0;
            read_reg <= 1'h0;
            rx_hold_reg <= 8'h00;
        end else begin
            SDA_OUT <= 1'h0;
            if (bus_start) begin
                start_reg <= 1'h1;
                stop_reg <= 1'h0;
                state_reg <= ST_ADDR;
                cnt_reg <= 4'h0;
                SDA_OE <= 1'h0;
            end else if (bus_stop) begin
                stop_reg <= 1'h1;
                start_reg <= 1'h0;
                state_reg <= ST_IDLE;
                SDA_OE <= 1'h0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        // Not addressed: stay off the line until the next start
                        SDA_OE <= 1'h0;
                    end
                    ST_ADDR, ST_RXD: begin
                        if (scl_rise && !byte_done) begin
                            rx_sh_reg <= {rx_sh_reg[6:0], sda_s2_reg};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            if (state_reg == ST_RXD) begin
                                data_reg <= 1'h1;
                                rx_hold_reg <= rx_sh_reg;
                                SDA_OE <= 1'h1;
                                state_reg <= ST_ACK_D;
                            end else if (addr_hit) begin
                                data_reg <= 1'h0;
                                read_reg <= rx_sh_reg[0];
                                SDA_OE <= 1'h1;
                                state_reg <= ST_ACK_A;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_D: begin
                        if (scl_fall) begin
                            SDA_OE <= 1'h0;
                            cnt_reg <= 4'h0;
                            state_reg <= ST_RXD;
                        end
                    end
                    ST_ACK_A, ST_TXACK: begin
                        if (scl_rise && state_reg == ST_TXACK) begin
                            nack_reg <= sda_s2_reg;
                        end else if (scl_fall) begin
                            cnt_reg <= 4'h0;
                            if (state_reg == ST_ACK_A && !read_reg) begin
                                SDA_OE <= 1'h0;
                                state_reg <= ST_RXD;
                            end else if (state_reg == ST_TXACK && nack_reg) begin
                                // Master refused more data: release the line
                                SDA_OE <= 1'h0;
                                state_reg <= ST_IDLE;
                            end else begin
                                // An empty holding register still sends its old byte
                                // Drive a zero bit as pulled low, a one as released
                                SDA_OE <= ~tx_hold_reg[7];
                                tx_sh_reg <= {tx_hold_reg[6:0], 1'h0};
                                state_reg <= ST_TXD;
                            end
                        end
                    end
                    ST_TXD: begin
                        if (scl_rise && !byte_done) begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (byte_done) begin
                                SDA_OE <= 1'h0;
                                nack_reg <= 1'h0;
                                state_reg <= ST_TXACK;
                            end else begin
                                SDA_OE <= ~tx_sh_reg[7];
                                tx_sh_reg <= {tx_sh_reg[6:0], 1'h0};
                            end
                        end
                    end
                    default: begin
                        SDA_OE <= 1'h0;
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Register side: flags, holding registers, interrupt
    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            own_addr_reg <= `I2ST_OWN_ADDR_RST;
            en_reg <= `I2ST_EN_RST;
            tx_hold_reg <= 8'h00;
            rxfull_reg <= 1'h0;
            txfull_reg <= 1'h0;
            ist_reg <= {`I2ST_EV_W{1'b0}};
            imask_reg <= {`I2ST_EV_W{1'b0}};
            RDATA <= 32'h0000_0000;
            IRQ <= 1'h0;
        end else begin
            if (wr_status) begin
                own_addr_reg <= WDATA[`I2ST_CTRL_ADDR_HI:0];
                en_reg <= WDATA[`I2ST_CTRL_EN];
            end
            if (wr_txhold) begin
                tx_hold_reg <= WDATA[7:0];
            end
            if (wr_irq_mask) begin
                imask_reg <= WDATA[`I2ST_EV_W-1:0];
            end
            // set by received byte, wins over read clear
            if (ev_rx) begin
                rxfull_reg <= 1'h1;
            end else if (rd_rxhold) begin
                rxfull_reg <= 1'h0;
            end
            if (wr_txhold) begin
                txfull_reg <= 1'h1;
            end else if (ev_txdone) begin
                txfull_reg <= 1'h0;
            end
            // Sticky events, write one to clear; a new event wins
            ist_reg <= (ist_reg & ~ist_clr) | ev_vec;
            // Registered so the pin cannot glitch while status or mask change
            IRQ <= |(ist_reg & imask_reg);
            // Read data stand one cycle only, zero otherwise
            RDATA <= 32'h0000_0000;
            if (RD) begin
                case (ADDR)
                    `I2ST_OFF_STATUS: begin
                        RDATA[`I2ST_ST_DATA] <= data_reg;
                        RDATA[`I2ST_ST_STOP] <= stop_reg;
                        RDATA[`I2ST_ST_START] <= start_reg;
                        RDATA[`I2ST_ST_READ] <= read_reg;
                        RDATA[`I2ST_ST_RXFULL] <= rxfull_reg;
                        RDATA[`I2ST_ST_TXFULL] <= txfull_reg;
                    end
                    `I2ST_OFF_CTRL: begin
                        RDATA[`I2ST_CTRL_ADDR_HI:0] <= own_addr_reg;
                        RDATA[`I2ST_CTRL_EN] <= en_reg;
                    end
                    `I2ST_OFF_RXHOLD: RDATA[7:0] <= rx_hold_reg;
                    `I2ST_OFF_TXHOLD: RDATA[7:0] <= tx_hold_reg;
                    `I2ST_OFF_IRQ_STAT: RDATA[`I2ST_EV_W-1:0] <= ist_reg;
                    `I2ST_OFF_IRQ_MASK: RDATA[`I2ST_EV_W-1:0] <= imask_reg;
                    default: RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // i2st_top

// ### dv/i2st_checker.sv
// Port-level checks of the status flags, bound to i2st_top.
// Assumes the bench resolves SDA and holds SCL still between frames.
`timescale 1ns/1ps
module i2st_checker (
    // Clock and reset
    input wire SYS_CLK,
    input wire SYS_RST,
    // Serial bus pins
    input wire SCL_IN,
    input wire SDA_IN,
    input wire SDA_OUT,
    input wire SDA_OE,
    // Register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    // Interrupt
    input wire IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    reg scl_p, sda_p, oe_p, seen, lstop, acked, dir_e, dat_e, rdm, fb;
    reg [3:0] cnt;
    reg [3:0] age;
    reg [7:0] sh;
    wire st = scl_p && SCL_IN && sda_p && !SDA_IN;
    wire sp = scl_p && SCL_IN && !sda_p && SDA_IN;
    wire rs = RD && ADDR == 8'h00;
    // Raw pins are a few cycles ahead of the block, so flags are judged once settled
    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            {scl_p, sda_p, oe_p, seen, lstop, acked, dir_e, dat_e, rdm, fb} <= 10'h300;
            cnt <= 4'h0;
            age <= 4'h0;
            sh <= 8'h00;
        end else begin
            scl_p <= SCL_IN;
            sda_p <= SDA_IN;
            oe_p <= SDA_OE;
            if (st || sp) begin
                seen <= 1'b1;
                lstop <= sp;
                age <= 4'h0;
                cnt <= 4'h0;
                fb <= 1'b1;
                rdm <= 1'b0;
            end else if (age != 4'hF) begin
                age <= age + 4'h1;
            end
            if (!scl_p && SCL_IN) begin
                sh <= {sh[6:0], SDA_IN};
                cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            end
            if (SDA_OE && !oe_p && cnt == 4'h8 && !rdm) begin
                acked <= 1'b1;
                fb <= 1'b0;
                dat_e <= !fb;
                if (fb) begin
                    dir_e <= sh[0];
                    rdm <= sh[0];
                end
            end
        end
    end
    property p_stop; rs && seen && age > 4'h5 |=> RDATA[4] == lstop; endproperty
    a_stop: assert property (p_stop) else $error("stop flag wrong");
    property p_start; rs && seen && age > 4'h5 |=> RDATA[3] == !lstop; endproperty
    a_start: assert property (p_start) else $error("start flag wrong");
    property p_pair; rs |=> !(RDATA[4] && RDATA[3]); endproperty
    a_pair: assert property (p_pair) else $error("start and stop both set");
    property p_data; rs && acked |=> RDATA[5] == dat_e; endproperty
    a_data: assert property (p_data) else $error("data flag wrong");
    property p_dir; rs && acked |=> RDATA[2] == dir_e; endproperty
    a_dir: assert property (p_dir) else $error("direction flag wrong");
    property p_rxclr; RD && ADDR == 8'h08 ##1 rs |=> !RDATA[1]; endproperty
    a_rxclr: assert property (p_rxclr) else $error("receive full not cleared");
    property p_txset; WR && ADDR == 8'h0C ##1 rs |=> RDATA[0]; endproperty
    a_txset: assert property (p_txset) else $error("transmit full not set");
    c_ack: cover property ($rose(SDA_OE));
    c_irq: cover property ($rose(IRQ));
    c_read: cover property (rs && acked && dir_e);
endmodule // i2st_checker
bind i2st_top i2st_checker u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));

// ### dv/i2st_bus_master.sv
// Behavioural bus master facing the slave; 48 ns bit period.
// Assumes the bench resolves the line from the slave's enable, pull-up high.
`timescale 1ns/1ps
module i2st_bus_master (
    // Bus pins
    output reg scl,
    output reg sda_m,
    input wire sda_line
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Also a repeated start; data falls while the clock is high
    task start;
        begin
            #6 sda_m <= 1'b1;
            #18 scl <= 1'b1;
            #24 sda_m <= 1'b0;
            #24 scl <= 1'b0;
        end
    endtask
    task stop;
        begin
            #6 sda_m <= 1'b0;
            #18 scl <= 1'b1;
            #24 sda_m <= 1'b1;
            #24;
        end
    endtask
    // Eight bits and the acknowledge slot, MSB first; a one releases the line
    task xfer(input [8:0] tx, output [8:0] rx);
        integer k;
        begin
            for (k = 8; k >= 0; k = k - 1) begin
                #6 sda_m <= tx[k];
                #18 scl <= 1'b1;
                #12 rx[k] = sda_line;
                #12 scl <= 1'b0;
            end
        end
    endtask
endmodule // i2st_bus_master

// ### dv/tb.sv
// Self-checking bench of i2st_top with a bus master model.
// Assumes the design file and its header are compiled first.
`timescale 1ns/1ps
module tb;
    reg SYS_CLK = 0, SYS_RST = 1, WR = 0, RD = 0;
    reg [7:0] ADDR = 0, b;
    reg [31:0] WDATA = 0, d;
    reg [8:0] rx;
    wire [31:0] RDATA;
    wire IRQ, SDA_OUT, SDA_OE, scl, sda_m;
    wire sda = sda_m & ~SDA_OE;
    integer err_count = 0, comparisons = 0, seed = 32'h0df516aa, i;
    always #2 SYS_CLK = ~SYS_CLK;
    i2st_top DUT (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ(IRQ));
    i2st_bus_master PM (.scl(scl), .sda_m(sda_m), .sda_line(sda));
    function [31:0] st(input dat, stp, sta, dir, rxf, txf);
        st = {26'h0, dat, stp, sta, dir, rxf, txf};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            ADDR <= a; WDATA <= v; WR <= 1'b1;
            @(posedge SYS_CLK) WR <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, output [31:0] v);
        begin
            ADDR <= a; RD <= 1'b1;
            @(posedge SYS_CLK) RD <= 1'b0;
            #1 v = RDATA;
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge SYS_CLK);
            #1;
        end
    endtask
    task close_out;
        begin
            if (err_count == 0 && comparisons > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Whole run needs well under 5000 clocks
    initial begin
        #200000;
        err_count = err_count + 1;
        close_out;
    end
    initial begin
        repeat (12) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        idle(1);
        rd(8'h00, d); chk(d, 0); rd(8'h04, d); chk(d, 32'h2A); rd(8'h18, d); chk(d, 0);
        wr(8'h04, 32'hAA); wr(8'h14, 32'h1F);
        rd(8'h04, d);
        chk(d, 32'hAA);
        rd(8'h14, d);
        chk(d, 32'hF);
        // Foreign address is left unanswered
        PM.start; PM.xfer(9'h0AD, rx); chk(rx[0], 1); PM.stop;
        idle(8); rd(8'h00, d); chk(d, st(0, 1, 0, 0, 0, 0));
        PM.start; PM.xfer(9'h0A9, rx); chk(rx[0], 0);
        idle(8); rd(8'h00, d); chk(d, st(0, 0, 1, 0, 0, 0));
        for (i = 0; i < 3; i = i + 1) begin
            d = $random(seed);
            b = d[7:0];
            PM.xfer({b, 1'b1}, rx); chk(rx[0], 0);
            idle(8); rd(8'h00, d); chk(d, st(1, 0, 1, 0, 1, 0));
            rd(8'h08, d); chk(d, b); rd(8'h00, d); chk(d, st(1, 0, 1, 0, 0, 0));
            chk(IRQ, 1); wr(8'h10, 32'h1F); idle(2); chk(IRQ, 0);
        end
        wr(8'h0C, {24'h0, b}); rd(8'h00, d); chk(d[0], 1);
        rd(8'h0C, d);
        chk(d, b);
        // Repeated start turns the bus round for a read
        PM.start; PM.xfer(9'h0AB, rx); chk(rx[0], 0);
        idle(8); rd(8'h00, d); chk(d, st(0, 0, 1, 1, 0, 1));
        chk(SDA_OUT, 0);
        // Master acknowledges the first byte, so the held byte goes out again
        PM.xfer(9'h1FE, rx);
        chk(rx[8:1], b);
        idle(8);
        rd(8'h00, d);
        chk(d, st(0, 0, 1, 1, 0, 0));
        PM.xfer(9'h1FF, rx);
        chk(rx[8:1], b);
        PM.stop;
        idle(8); rd(8'h00, d); chk(d, st(0, 1, 0, 1, 0, 0));
        // A frame cut right after its start leaves data and direction alone
        PM.start;
        idle(8);
        rd(8'h00, d);
        chk(d, st(0, 0, 1, 1, 0, 0));
        PM.stop;
        idle(8);
        rd(8'h00, d);
        chk(d, st(0, 1, 0, 1, 0, 0));
        wr(8'h14, 32'h0); idle(2); chk(IRQ, 0);
        rd(8'h10, d); chk(d & 32'h6, 32'h6);
        wr(8'h14, 32'h1F); idle(2); chk(IRQ, 1);
        wr(8'h10, 32'h1F); idle(2); chk(IRQ, 0);
        close_out;
    end
endmodule // tb
